// file: hefg_pkg.sv
// Package of constants and types for the host end-of-frame guard
package hefg_pkg;
   // ********************************************************************
   // Frame and threshold constants (full-speed bit times)
   // ********************************************************************
   localparam int            FS_BIT_NS        = 83;
   localparam int            CLK_NS           = 4;
   localparam logic [3:0]    BIT_DIV_RST      = 4'h0;
   localparam logic [13:0]   FRAME_BITS       = 14'h2EDF;
   localparam logic [13:0]   LAST_START_BT    = 14'h002A;
   localparam logic [13:0]   RX_CUTOFF_BT     = 14'h0029;
   localparam logic [13:0]   FS_HS_EOP_BT     = 14'h004C;
   localparam logic [13:0]   LS_HS_EOP_BT     = 14'h0149;
   localparam logic [13:0]   LS_FSEOP_EXTRA   = 14'h000D;
   localparam logic [13:0]   IN_TOKEN_BITS    = 14'h0022;
   localparam logic [13:0]   HDR_CRC_BITS     = 14'h0020;
   localparam logic [13:0]   TURN_BITS        = 14'h0012;
   localparam logic [13:0]   LS_PREAMBLE_BITS = 14'h0014;
   localparam logic [13:0]   LS_SCALE_SHIFT   = 14'h0003;
   localparam logic [2:0]    ABORT_ONES       = 3'h7;
   localparam logic [1:0]    EOP_BITS         = 2'h3;
   localparam logic [3:0]    LS_BIT_FS        = 4'h8;

   typedef enum logic [1:0] {ABT_IDLE, ABT_ONES, ABT_EOP} hefg_abort_e;
endpackage : hefg_pkg

// file: hefg_bit_tick.sv
// Full-speed bit-time enable divider
`timescale 1ns/1ps
`default_nettype none
module hefg_bit_tick
   import hefg_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sync,
   output logic      tick
);
   // Twelve MHz is not an integer divide of 250 MHz; an accumulator keeps
   // the long-run rate exact at the cost of one cycle of jitter per bit.
   localparam logic [9:0] ACC_STEP = 10'h00C;
   localparam logic [9:0] ACC_MOD  = 10'h0FA;
   logic [9:0] accQ;
   logic [9:0] accD;
   logic       tickD;
   logic       tickQ;

   always_comb
   begin
      tickD = 1'b0;
      accD  = accQ + ACC_STEP;
      if (sync)
      begin
         accD = '0;
      end
      else if (accD >= ACC_MOD)
      begin
         accD  = accD - ACC_MOD;
         tickD = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accQ  <= '0;
         tickQ <= 1'b0;
      end
      else
      begin
         accQ  <= accD;
         tickQ <= tickD;
      end
   end

   assign tick = tickQ;
endmodule : hefg_bit_tick
`default_nettype wire

// file: hefg_guard.sv
// End-of-frame transaction guard for a full/low-speed host
`timescale 1ns/1ps
`default_nettype none
module hefg_guard
   import hefg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sofStart,
   input  wire logic        txStartReq,
   input  wire logic        txIsInToken,
   input  wire logic        txLowSpeed,
   input  wire logic [10:0] maxRespBytes,
   input  wire logic        txDataActive,
   input  wire logic        txDataNonIso,
   input  wire logic        rxActive,
   input  wire logic        rxStartPredOk,
   input  wire logic        acceptPredicted,
   input  wire logic        lsFsEopOk,
   input  wire logic        strictMode,
   output logic [13:0]      bitTime,
   output logic             txStartOk,
   output logic             dataHsFitOk,
   output logic             rxDiscard,
   output logic             abortActive,
   output logic             abortBit,
   output logic             abortEop,
   output logic             abortLowSpeed
);
   // ********************************************************************
   // Worst-case IN interval
   // ********************************************************************
   function automatic logic [13:0] inInterval(input logic [10:0] nBytes,
                                              input logic        ls,
                                              input logic        strict);
      logic [17:0] bits;
      logic [17:0] total;
      begin
         bits  = {4'h0, nBytes, 3'h0} + {4'h0, HDR_CRC_BITS};
         total = (bits * 18'd7 + 18'd5) / 18'd6;
         total = total + {4'h0, IN_TOKEN_BITS} + {4'h0, TURN_BITS};
         if (strict)
         begin
            total = total + {4'h0, TURN_BITS} + 18'd16;
         end
         if (ls)
         begin
            total = (total << LS_SCALE_SHIFT) + {4'h0, LS_PREAMBLE_BITS};
         end
         if (total > 18'h3FFF)
         begin
            inInterval = 14'h3FFF;
         end
         else
         begin
            inInterval = total[13:0];
         end
      end
   endfunction : inInterval

   // ********************************************************************
   // Frame bit counter
   // ********************************************************************
   logic        tick;
   logic [13:0] cntQ;
   logic [13:0] cntD;

   hefg_bit_tick uTick (
      .clk   (clk),
      .rst_n (rst_n),
      .sync  (sofStart),
      .tick  (tick)
   );

   always_comb
   begin
      cntD = cntQ;
      if (sofStart)
      begin
         cntD = FRAME_BITS;
      end
      else if (tick && cntQ != 14'h0000)
      begin
         cntD = cntQ - 14'h0001;
      end
   end

   // ********************************************************************
   // Start and receive decisions
   // ********************************************************************
   logic [13:0] need;
   logic [14:0] needTot;
   logic [13:0] lsLimit;
   logic        startOkD;
   logic        hsOkD;
   logic        discardQ;
   logic        discardD;

   always_comb
   begin
      need     = inInterval(maxRespBytes, txLowSpeed, strictMode);
      needTot  = {1'b0, need} + {1'b0, RX_CUTOFF_BT};
      lsLimit  = lsFsEopOk ? LS_HS_EOP_BT : LS_HS_EOP_BT + LS_FSEOP_EXTRA;
      // Judged on the coming count so a grant never outlives bit time 42
      startOkD = (cntD >= LAST_START_BT);
      if (txIsInToken && ({1'b0, cntD} < needTot))
      begin
         startOkD = 1'b0;
      end
      hsOkD = txLowSpeed ? (cntQ > lsLimit) : (cntQ > FS_HS_EOP_BT);
      discardD = discardQ;
      // A hub-forced EOP looks like a normal end, so anything still arriving at the
      // cutoff is poisoned until the receiver idles, unless acceptPredicted and rxStartPredOk are both set.
      if (!rxActive)
      begin
         discardD = 1'b0;
      end
      else if (cntQ <= RX_CUTOFF_BT && !(acceptPredicted && rxStartPredOk))
      begin
         discardD = 1'b1;
      end
   end

   // ********************************************************************
   // Abnormal termination sequencer
   // ********************************************************************
   hefg_abort_e abtQ;
   hefg_abort_e abtD;
   logic [2:0]  abtCntQ;
   logic [2:0]  abtCntD;
   logic [3:0]  lsDivQ;
   logic [3:0]  lsDivD;
   logic        abtLsQ;
   logic        abtLsD;
   logic        abtStep;
   logic        hitLimit;

   always_comb
   begin
      abtD     = abtQ;
      abtCntD  = abtCntQ;
      abtLsD   = abtLsQ;
      lsDivD   = lsDivQ;
      abtStep  = 1'b0;
      // Fires on the tick that enters the limit, so the abort begins in that bit
      hitLimit = txLowSpeed ? (cntD == lsLimit) : (cntD == FS_HS_EOP_BT);
      if (tick)
      begin
         lsDivD = (lsDivQ == LS_BIT_FS - 4'h1) ? BIT_DIV_RST : lsDivQ + 4'h1;
         abtStep = !abtLsQ || (lsDivQ == LS_BIT_FS - 4'h1);
      end
      case (abtQ)
         ABT_IDLE:
         begin
            if (tick && hitLimit && txDataActive && txDataNonIso)
            begin
               abtD    = ABT_ONES;
               abtCntD = '0;
               abtLsD  = txLowSpeed;
               lsDivD  = BIT_DIV_RST;
            end
         end
         ABT_ONES:
         begin
            if (abtStep)
            begin
               abtCntD = abtCntQ + 3'h1;
               if (abtCntQ == ABORT_ONES - 3'h1)
               begin
                  abtD    = ABT_EOP;
                  abtCntD = '0;
               end
            end
         end
         ABT_EOP:
         begin
            if (abtStep)
            begin
               abtCntD = abtCntQ + 3'h1;
               if (abtCntQ == {1'b0, EOP_BITS} - 3'h1)
               begin
                  abtD = ABT_IDLE;
               end
            end
         end
         default:
         begin
            abtD = ABT_IDLE;
         end
      endcase
   end

   // ********************************************************************
   // State registers
   // ********************************************************************
   logic startOkQ;
   logic hsOkQ;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cntQ     <= '0;
         startOkQ <= 1'b0;
         hsOkQ    <= 1'b0;
         discardQ <= 1'b0;
         abtQ     <= ABT_IDLE;
         abtCntQ  <= '0;
         abtLsQ   <= 1'b0;
         lsDivQ   <= BIT_DIV_RST;
      end
      else
      begin
         cntQ     <= cntD;
         startOkQ <= startOkD;
         hsOkQ    <= hsOkD;
         discardQ <= discardD;
         abtQ     <= abtD;
         abtCntQ  <= abtCntD;
         abtLsQ   <= abtLsD;
         lsDivQ   <= lsDivD;
      end
   end

   // Gating start with the request keeps a stale grant from leaking out
   assign bitTime       = cntQ;
   assign txStartOk     = startOkQ && txStartReq && (abtQ == ABT_IDLE);
   assign dataHsFitOk   = hsOkQ;
   assign rxDiscard     = discardQ;
   assign abortActive   = (abtQ != ABT_IDLE);
   assign abortBit      = (abtQ == ABT_ONES);
   assign abortEop      = (abtQ == ABT_EOP);
   assign abortLowSpeed = abtLsQ;
endmodule : hefg_guard
`default_nettype wire

// file: hefg_guard_properties.sv
// Port checks for the end-of-frame guard
`timescale 1ns/1ps
`default_nettype none
module hefg_guard_properties
   import hefg_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        sofStart,
   input wire logic        lsFsEopOk,
   input wire logic        rxActive,
   input wire logic        acceptPredicted,
   input wire logic [13:0] bitTime,
   input wire logic        txStartOk,
   input wire logic        rxDiscard,
   input wire logic        abortActive,
   input wire logic        abortBit,
   input wire logic        abortEop,
   input wire logic        abortLowSpeed
);
   // ********
   // Assertions
   // ********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_ones; abortActive && abortBit; endsequence
   sequence s_eop; abortActive && abortEop; endsequence
   a_sof_reload: assert property (sofStart |=> bitTime == FRAME_BITS)
      else $error("bit time not reloaded");
   a_count_down: assert property ($changed(bitTime) && !$past(sofStart)
      |-> bitTime == $past(bitTime) - 14'h0001) else $error("bit time not counting down");
   a_late_start: assert property (bitTime < LAST_START_BT
      && $past(bitTime) < LAST_START_BT |-> !txStartOk) else $error("late start");
   a_abort_blocks: assert property (abortActive |-> !txStartOk)
      else $error("start during abort");
   a_abort_order: assert property (s_ones ##1 !abortBit |-> s_eop)
      else $error("ones not followed by end of packet");
   a_abort_point: assert property ($rose(abortBit) |-> bitTime ==
      (!abortLowSpeed ? FS_HS_EOP_BT : lsFsEopOk ? LS_HS_EOP_BT : LS_HS_EOP_BT + LS_FSEOP_EXTRA))
      else $error("abort at wrong bit time");
   a_discard_late: assert property (rxActive && !acceptPredicted
      && bitTime <= RX_CUTOFF_BT && $past(bitTime) <= RX_CUTOFF_BT |=> rxDiscard)
      else $error("late packet kept");
   a_discard_clear: assert property (!rxActive |=> !rxDiscard)
      else $error("discard without packet");
endmodule : hefg_guard_properties
bind hefg_guard hefg_guard_properties hefg_guard_properties_i (.clk(clk), .rst_n(rst_n),
   .sofStart(sofStart), .lsFsEopOk(lsFsEopOk), .rxActive(rxActive),
   .acceptPredicted(acceptPredicted), .bitTime(bitTime), .txStartOk(txStartOk),
   .rxDiscard(rxDiscard), .abortActive(abortActive), .abortBit(abortBit),
   .abortEop(abortEop), .abortLowSpeed(abortLowSpeed));
`default_nettype wire

// file: hefg_dev_model.sv
// Downstream device answering with a handshake
`timescale 1ns/1ps
`default_nettype none
module hefg_dev_model
   import hefg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [13:0] bitTime,
   output var  logic        rxActive,
   output var  logic        rxStartPredOk
);
   localparam int TURN_CLK = 17 * FS_BIT_NS / CLK_NS;
   localparam int HS_CLK   = 16 * FS_BIT_NS / CLK_NS;
   always
   begin
      rxActive      <= 1'b0;
      rxStartPredOk <= 1'b0;
      @(posedge clk iff go);
      repeat (TURN_CLK) @(posedge clk);
      #1;
      rxStartPredOk <= (bitTime >= RX_CUTOFF_BT);
      rxActive      <= 1'b1;
      // A hub on the path cuts the reply short at its first end-of-frame point
      for (int i = 0; i < HS_CLK && bitTime > 14'h0020; i++) #(CLK_NS);
   end
endmodule : hefg_dev_model
`default_nettype wire

// file: test_hefg_guard.sv
// Self-checking bench for the end-of-frame guard
`timescale 1ns/1ps
`default_nettype none
module test_hefg_guard
   import hefg_pkg::*;
;
   logic        clk, rst_n, sofStart, txStartReq, txIsInToken, txLowSpeed, go;
   logic        txDataActive, txDataNonIso, acceptPredicted, lsFsEopOk, strictMode;
   logic [10:0] maxRespBytes;
   logic [13:0] bitTime;
   logic        txStartOk, dataHsFitOk, rxDiscard, rxActive, rxStartPredOk;
   logic        abortActive, abortBit, abortEop, abortLowSpeed;
   int          errTotal, cmpCount;

   hefg_guard hefg_guard_i (.clk(clk), .rst_n(rst_n), .sofStart(sofStart),
      .txStartReq(txStartReq), .txIsInToken(txIsInToken), .txLowSpeed(txLowSpeed),
      .maxRespBytes(maxRespBytes), .txDataActive(txDataActive), .txDataNonIso(txDataNonIso),
      .rxActive(rxActive), .rxStartPredOk(rxStartPredOk), .acceptPredicted(acceptPredicted),
      .lsFsEopOk(lsFsEopOk), .strictMode(strictMode), .bitTime(bitTime),
      .txStartOk(txStartOk), .dataHsFitOk(dataHsFitOk), .rxDiscard(rxDiscard),
      .abortActive(abortActive), .abortBit(abortBit), .abortEop(abortEop),
      .abortLowSpeed(abortLowSpeed));
   hefg_dev_model hefg_dev_model_i (.clk(clk), .go(go), .bitTime(bitTime),
      .rxActive(rxActive), .rxStartPredOk(rxStartPredOk));

   // ********
   // Helpers
   // ********
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
      cmpCount++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic till(input logic [13:0] n);
      for (int k = 0; k < 260000 && bitTime !== n; k++) step();
      chk("bitTime", bitTime, n);
   endtask : till
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // ********
   // Scenarios
   // ********
   task automatic t_reset;
      chk("bitTime", bitTime, 14'h0000);
      rst_n = 1'b1;
      txStartReq = 1'b1;
      step(3);
      chk("txStartOk", txStartOk, 1'b0);
      sofStart = 1'b1;
      step();
      sofStart = 1'b0;
      chk("bitTime", bitTime, FRAME_BITS);
      till(FRAME_BITS - 14'h0001);
      $display("test reset done");
   endtask : t_reset
   task automatic t_in;
      // 64-byte reply: 687 bits, strict +34, low speed x8 +20; then +41
      logic [13:0] at [6] = '{14'h16A8, 14'h15E0, 14'h157C, 14'h02EE, 14'h02E4,
                              14'h02BC};
      logic [2:0]  md [6] = '{3'b110, 3'b101, 3'b100, 3'b010, 3'b001, 3'b000};
      txIsInToken = 1'b1;
      foreach (at[i])
      begin
         till(at[i]);
         {txLowSpeed, strictMode} = md[i][2:1];
         step(3);
         chk("txStartOk", txStartOk, md[i][0]);
      end
      {txIsInToken, txLowSpeed, strictMode} = '0;
      $display("test in token done");
   endtask : t_in
   task automatic t_abort(input logic ls);
      logic [13:0] thr;
      int          m;
      thr = ls ? LS_HS_EOP_BT + LS_FSEOP_EXTRA : FS_HS_EOP_BT;
      m = ls ? 8 : 1;
      till(thr + 14'h0008);
      {txDataActive, txDataNonIso, txLowSpeed, lsFsEopOk} = {2'b11, ls, !ls};
      step(3);
      chk("dataHsFitOk", dataHsFitOk, 1'b1);
      for (int k = 0; k < 400 && abortBit !== 1'b1; k++) step();
      chk("abortStart", bitTime, thr);
      chk("abortLowSpeed", abortLowSpeed, ls);
      chk("txStartOk", txStartOk, 1'b0);
      // Accepting a full-speed end on low speed moves the fit point down to 329
      till(thr - 14'h0005);
      lsFsEopOk = 1'b1;
      step(3);
      chk("dataHsFitOk", dataHsFitOk, ls);
      lsFsEopOk = !ls;
      for (int k = 0; k < 1500 && abortEop !== 1'b1; k++) step();
      chk("onesEnd", bitTime, thr - 14'(7 * m));
      chk("dataHsFitOk", dataHsFitOk, 1'b0);
      for (int k = 0; k < 800 && abortActive !== 1'b0; k++) step();
      chk("eopEnd", bitTime, thr - 14'(10 * m));
      {txDataActive, txDataNonIso, txLowSpeed} = '0;
      $display("test abort done");
   endtask : t_abort
   task automatic t_frame_end;
      till(14'h003C);
      go = 1'b1;
      acceptPredicted = 1'b1;
      step();
      go = 1'b0;
      till(14'h002B);
      step(3);
      chk("txStartOk", txStartOk, 1'b1);
      till(14'h002A);
      step(3);
      chk("rxDiscard", rxDiscard, 1'b0);
      till(14'h0028);
      step(3);
      chk("rxDiscard", rxDiscard, 1'b0);
      acceptPredicted = 1'b0;
      till(14'h0026);
      step(3);
      chk("rxDiscard", rxDiscard, 1'b1);
      chk("txStartOk", txStartOk, 1'b0);
      till(14'h001E);
      step(3);
      chk("rxDiscard", rxDiscard, 1'b0);
      $display("test frame end done");
   endtask : t_frame_end

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // A full frame takes about 1 ms
   initial
   begin
      #1200000;
      errTotal++;
      conclude();
   end
   initial
   begin
      {sofStart, txStartReq, txIsInToken, txLowSpeed, go} = '0;
      {txDataActive, txDataNonIso, acceptPredicted, lsFsEopOk, strictMode} = '0;
      maxRespBytes = 11'h040;
      errTotal = 0;
      cmpCount = 0;
      rst_n = 1'b0;
      step(2);
      t_reset();
      t_in();
      t_abort(1'b1);
      t_abort(1'b0);
      t_frame_end();
      conclude();
   end
endmodule : test_hefg_guard
`default_nettype wire
